// ===== atd_pkg.sv
// constants, types and register map of the alarm, trip display and
// reset control block; assumes a 25 MHz system clock
package atd_pkg;
  // clock and timing
  localparam int CLK_HZ = 25000000;
  localparam int FLASH_MS = 640; // alarm flash period
  localparam int PROG_FLASH_S = 10; // program alarm flash period
  localparam int CARD_FLASH_S = 2; // card save decimal point flash
  localparam int STEP_MS = 40; // keypad reference step interval
  localparam int ACCEL_MS = 1000; // hold time per rate doubling
  localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
  localparam int PROG_CYC = PROG_FLASH_S * CLK_HZ;
  localparam int CARD_CYC = CARD_FLASH_S * CLK_HZ;
  localparam int STEP_CYC = STEP_MS * (CLK_HZ / 1000);
  localparam int ACCEL_CYC = ACCEL_MS * (CLK_HZ / 1000);
  // thresholds, accumulators in 0.1 % units
  localparam logic [15:0] BRAKE_LIMIT = 16'h02EE; // 75.0 %
  localparam logic [15:0] OVL_LIMIT = 16'h02EE; // 75 %
  localparam logic [3:0] REFSEL_KEYPAD = 4'h4;
  localparam logic [15:0] UTRIP_RESET = 16'h0064; // 100
  localparam logic [15:0] ACT_DEFAULTS_A = 16'h04D1; // 1233
  localparam logic [15:0] ACT_DEFAULTS_B = 16'h04DC; // 1244
  localparam logic signed [15:0] REF_LIM = 16'sh7FF0; // rpm clamp
  localparam logic [2:0] MAX_SHIFT = 3'h4;
  // trip codes
  localparam logic [7:0] TRIP_UV = 8'h01;
  localparam logic [7:0] TRIP_EEF = 8'h1F;
  localparam logic [7:0] TRIP_HF_FIRST = 8'hC9; // first hardware fault
  localparam logic [7:0] TRIP_HF_LAST = 8'hD8; // sixteenth one
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_UTRIP = 8'h04;
  localparam logic [7:0] OFS_ACTION = 8'h08;
  localparam logic [7:0] OFS_RATED = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_KEYREF = 8'h14;
  // control register fields
  localparam int CTRL_REVEN = 4;
  localparam int CTRL_STOPEN = 5;
  localparam int CTRL_LATCH = 6;
  localparam int CTRL_MOTOR2 = 7;
  localparam int CTRL_RESET = 8;
  localparam logic [8:0] CTRL_RESET_VAL = 9'h020;
  // key indices
  localparam int KEY_PARAM = 0;
  localparam int KEY_UP = 1;
  localparam int KEY_DOWN = 2;
  localparam int KEY_STOP = 3;
  localparam int KEY_RUN = 4;
  localparam int KEY_REV = 5;
  localparam int NKEYS = 6;
  // alarms in priority order
  typedef enum logic [2:0] {
    ALM_NONE, ALM_BRAKE, ALM_OVL, ALM_HEAT, ALM_TUNE, ALM_LIMIT, ALM_PROG
  } atd_alarm_t;
  // display modes, gray along status, keypad reference, parameter
  typedef enum logic [1:0] {
    DM_STATUS = 2'b00, DM_KEYREF = 2'b01, DM_PARAM = 2'b11
  } atd_mode_t;
endpackage

// ===== atd_ramp_if.sv
// carrier between the top block and the keypad reference ramp
// assumes both ends share one clock
`timescale 1ns/100ps
interface atd_ramp_if;
  logic up; // up key held
  logic down; // down key held
  logic enable; // adjusting allowed
  logic signed [15:0] speedRef; // keypad speed reference, rpm
  modport ctl (output up, output down, output enable, input speedRef);
  modport ramp (input up, input down, input enable, output speedRef);
endinterface

// ===== atd_period.sv
// free running period counter giving a flash phase
// assumes one clock and a reset asserted at power up
`timescale 1ns/100ps
module atd_period #(
  parameter int unsigned PERIOD = 16000000,
  parameter int unsigned ONTIME = 8000000
) (
  input wire logic clock,
  input wire logic nrst,
  output logic phaseOn
);
  import atd_pkg::*;
  typedef struct packed {
    logic [27:0] cnt; // position in the period
    logic on; // first part of the period
  } atd_per_st_t;
  atd_per_st_t st, next_st;
  // count and decode the phase
  always_comb
  begin
    next_st = st;
    if (st.cnt == 28'(PERIOD - 1))
      next_st.cnt = '0;
    else
      next_st.cnt = st.cnt + 28'h0000001;
    next_st.on = (next_st.cnt < 28'(ONTIME));
  end
  // state register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      st <= '0;
    else
      st <= next_st;
  end
  assign phaseOn = st.on;
endmodule

// ===== atd_ramp.sv
// keypad speed reference with a step rate that doubles while held
// assumes key levels already synchronised to clock
`timescale 1ns/100ps
module atd_ramp #(
  parameter int unsigned STEP_CYC = 1000000,
  parameter int unsigned ACCEL_CYC = 25000000
) (
  input wire logic clock,
  input wire logic nrst,
  atd_ramp_if.ramp rif
);
  import atd_pkg::*;
  typedef struct packed {
    logic [24:0] stepCnt; // cycles since last step
    logic [24:0] holdCnt; // cycles since last doubling
    logic [2:0] shift; // step is 1 << shift
    logic held; // key already acting
    logic signed [15:0] speedRef; // reference value
  } atd_ramp_st_t;
  atd_ramp_st_t st, next_st;
  logic signed [16:0] sum;
  logic signed [16:0] step;
  // step on first press, then every interval with growing size
  always_comb
  begin
    next_st = st;
    step = 17'sd1 <<< st.shift;
    sum = rif.up ? 17'(st.speedRef) + step : 17'(st.speedRef) - step;
    if (!rif.enable || (rif.up == rif.down))
    begin
      next_st.held = 1'b0;
      next_st.shift = '0;
      next_st.stepCnt = '0;
      next_st.holdCnt = '0;
    end
    else
    begin
      next_st.held = 1'b1;
      if (!st.held || st.stepCnt == 25'(STEP_CYC - 1))
      begin
        next_st.stepCnt = '0;
        if (sum > 17'(REF_LIM))
          next_st.speedRef = REF_LIM;
        else if (sum < -17'(REF_LIM))
          next_st.speedRef = -REF_LIM;
        else
          next_st.speedRef = sum[15:0];
      end
      else
        next_st.stepCnt = st.stepCnt + 25'h0000001;
      // rate rises each hold interval the key stays held, until the step reaches 16
      if (st.holdCnt == 25'(ACCEL_CYC - 1))
      begin
        next_st.holdCnt = '0;
        if (st.shift != MAX_SHIFT)
          next_st.shift = st.shift + 3'h1;
      end
      else
        next_st.holdCnt = st.holdCnt + 25'h0000001;
    end
  end
  // state register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      st <= '0;
    else
      st <= next_st;
  end
  assign rif.speedRef = st.speedRef;
endmodule

// ===== atd_top.sv
// alarm and trip display plus drive reset control, APB slave
// assumes keys arrive from pins; drive signals share the clock
//
// Summary of operation
// - alternate alarm code with second row data
// - flash alarms every 640ms, program every 10s
// - no alarm display while a parameter edits
// - braking alarm above 75.0% while transistor switches
// - overload alarm above 75% and current above rated
// - heat alarm from heatsink or board alarm
// - autotune, limit stop and program alarms shown
// - trip enters status mode, flashes trip code
// - freeze monitored values on non-undervoltage trips
// - parameter key opens parameter view, except hardware faults
// - selector 4 gives keypad control, keys active
// - up/down in status adjusts shown keypad reference
// - held up/down speeds up reference change
// - stop key resets when stopped or stop disabled
// - reset on rising reset request bit
// - writing 100 to user trip resets drive
// - eeprom fault needs 1233/1244, then load defaults
// - non-latching sequencer restarts on enable and run
// - latching sequencer also needs not-stop active
// - after stop key reset, wait fresh run edge
// - second motor set lights a first row point
// - card save flashes right-most point two seconds
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps
module atd_top #(
  parameter int unsigned FLASH_CYC = atd_pkg::FLASH_CYC,
  parameter int unsigned PROG_CYC = atd_pkg::PROG_CYC,
  parameter int unsigned CARD_CYC = atd_pkg::CARD_CYC,
  parameter int unsigned STEP_CYC = atd_pkg::STEP_CYC,
  parameter int unsigned ACCEL_CYC = atd_pkg::ACCEL_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // keypad pins, high while pressed
  input wire logic [atd_pkg::NKEYS-1:0] keyPins,
  // drive side inputs
  input wire logic editActive, // a parameter is being edited
  input wire logic [15:0] brakeTherm, // resistor accumulator
  input wire logic brakeSwitching, // braking transistor active
  input wire logic [15:0] ovlAccum, // motor overload accumulator
  input wire logic [15:0] outCurrent, // output current
  input wire logic heatsinkAlarm,
  input wire logic boardAlarm,
  input wire logic autotuneActive,
  input wire logic limitStopActive,
  input wire logic programRunning,
  input wire logic tripActive,
  input wire logic [7:0] tripCode,
  input wire logic driveRunning,
  input wire logic enableIn,
  input wire logic notStopIn,
  input wire logic [2:0] runInputs, // run forward, reverse, run
  input wire logic cardSaved, // pulse, card save finished
  // display and control outputs
  output atd_pkg::atd_alarm_t alarmCode,
  output logic alarmShow,
  output logic tripRow1,
  output logic tripCodeShow,
  output atd_pkg::atd_mode_t dispMode,
  output logic freezeMonitors,
  output logic keypadControl,
  output logic revKeyActive,
  output logic signed [15:0] keyRef,
  output logic [1:0] decimalPoints,
  output logic stopCmd,
  output logic runCmd,
  output logic revCmd,
  output logic driveReset,
  output logic loadDefaults,
  output logic runPermit
);
  import atd_pkg::*;

  // whole block state
  typedef struct packed {
    logic [NKEYS-1:0] syncA; // first synchroniser stage
    logic [NKEYS-1:0] syncB; // second synchroniser stage
    logic [NKEYS-1:0] keyPrev; // for press edges
    logic [8:0] ctrl; // control register
    logic [15:0] utrip; // user trip value
    logic [15:0] action; // action value
    logic [15:0] rated; // rated current
    logic [31:0] rdata; // read data
    logic rerr; // unmapped access
    atd_mode_t mode;
    atd_alarm_t alarm;
    logic alarmShow;
    logic tripCodeShow;
    logic tripRow1;
    logic tripPrev;
    logic freeze;
    logic holdOff; // waiting for fresh run edge
    logic [2:0] runPrev;
    logic runPermit;
    logic driveReset;
    logic loadDefaults;
    logic stopCmd;
    logic runCmd;
    logic revCmd;
    logic [25:0] cardCnt; // card flash time left
    logic [1:0] dp;
  } atd_st_t;
  atd_st_t st, next_st;

  logic flashPhase; // 640 ms flash phase
  logic progPhase; // 10 s flash phase
  atd_ramp_if rampIf ();

  // alarm priority pick
  function automatic atd_alarm_t alarmPick(input logic [5:0] c);
    atd_alarm_t a;
    a = ALM_NONE;
    if (c[0])
      a = ALM_BRAKE;
    else if (c[1])
      a = ALM_OVL;
    else if (c[2])
      a = ALM_HEAT;
    else if (c[3])
      a = ALM_TUNE;
    else if (c[4])
      a = ALM_LIMIT;
    else if (c[5])
      a = ALM_PROG;
    return a;
  endfunction

  // register address decode, used only for the error response to reads and writes
  function automatic logic mapped(input logic [7:0] a);
    return a == OFS_CTRL || a == OFS_UTRIP || a == OFS_ACTION ||
      a == OFS_RATED || a == OFS_STATUS || a == OFS_KEYREF;
  endfunction

  atd_period #(.PERIOD(FLASH_CYC), .ONTIME(FLASH_CYC / 2)) uFlash (
    .clock(clock),
    .nrst(nrst),
    .phaseOn(flashPhase)
  );
  atd_period #(.PERIOD(PROG_CYC), .ONTIME(FLASH_CYC / 2)) uProg (
    .clock(clock),
    .nrst(nrst),
    .phaseOn(progPhase)
  );
  atd_ramp #(.STEP_CYC(STEP_CYC), .ACCEL_CYC(ACCEL_CYC)) uRamp (
    .clock(clock),
    .nrst(nrst),
    .rif(rampIf)
  );

  logic [NKEYS-1:0] press; // key press edges, gated
  logic hfTrip; // hardware fault trip
  logic eefTrip; // eeprom fault trip
  logic keypadCtl; // keypad control selected
  logic wr; // APB write strobe
  logic brakeCond;
  logic ovlCond;
  logic stopReset;
  logic paramReset;
  logic commsReset;
  logic eefOk;
  logic doReset;
  logic anyRun;

  // decode of inputs and reset sources
  always_comb
  begin
    hfTrip = tripActive && tripCode >= TRIP_HF_FIRST &&
      tripCode <= TRIP_HF_LAST;
    eefTrip = tripActive && tripCode == TRIP_EEF;
    press = hfTrip ? '0 : (st.syncB & ~st.keyPrev);
    keypadCtl = st.ctrl[3:0] == REFSEL_KEYPAD;
    wr = psel && penable && pwrite;
    brakeCond = brakeTherm > BRAKE_LIMIT && brakeSwitching;
    ovlCond = ovlAccum > OVL_LIMIT && outCurrent > st.rated;
    // stop key resets unless it is acting as a running stop
    stopReset = press[KEY_STOP] && (!driveRunning ||
      !st.ctrl[CTRL_STOPEN] || st.syncB[KEY_RUN]);
    paramReset = wr && paddr == OFS_CTRL && pwdata[CTRL_RESET] &&
      !st.ctrl[CTRL_RESET];
    commsReset = wr && paddr == OFS_UTRIP &&
      pwdata[15:0] == UTRIP_RESET;
    eefOk = st.action == ACT_DEFAULTS_A ||
      st.action == ACT_DEFAULTS_B;
    doReset = (stopReset || paramReset || commsReset) &&
      (!eefTrip || eefOk);
    anyRun = |runInputs;
  end

  // ramp only adjusts in keypad control outside parameter view
  always_comb
  begin
    rampIf.enable = keypadCtl && st.mode != DM_PARAM && !hfTrip &&
      !editActive;
    rampIf.up = st.syncB[KEY_UP];
    rampIf.down = st.syncB[KEY_DOWN];
  end

  // next state of the whole block
  always_comb
  begin
    next_st = st;
    // keys: two flip-flops from the pins
    next_st.syncA = keyPins;
    next_st.syncB = st.syncA;
    next_st.keyPrev = st.syncB;
    // APB writes
    if (wr)
    begin
      unique case (paddr)
        OFS_CTRL: next_st.ctrl = pwdata[8:0];
        OFS_UTRIP: next_st.utrip = pwdata[15:0];
        OFS_ACTION: next_st.action = pwdata[15:0];
        OFS_RATED: next_st.rated = pwdata[15:0];
        default: ;
      endcase
    end
    // APB read data captured in the setup cycle
    if (psel && !penable)
    begin
      next_st.rerr = !mapped(paddr);
      unique case (paddr)
        OFS_CTRL: next_st.rdata = {23'h0, st.ctrl};
        OFS_UTRIP: next_st.rdata = {16'h0, st.utrip};
        OFS_ACTION: next_st.rdata = {16'h0, st.action};
        OFS_RATED: next_st.rdata = {16'h0, st.rated};
        OFS_STATUS: next_st.rdata = {20'h0, eefTrip, st.runPermit,
          st.holdOff, keypadCtl, st.mode, st.freeze, tripActive,
          st.alarmShow, st.alarm};
        OFS_KEYREF: next_st.rdata = {16'h0, rampIf.speedRef};
        default: next_st.rdata = '0;
      endcase
    end
    // alarm choice and flashing
    next_st.alarm = alarmPick({programRunning, limitStopActive,
      autotuneActive, heatsinkAlarm || boardAlarm, ovlCond,
      brakeCond});
    next_st.alarmShow = next_st.alarm != ALM_NONE && !editActive &&
      !tripActive && ((next_st.alarm == ALM_PROG) ? progPhase :
      flashPhase);
    // trip display and freeze
    next_st.tripPrev = tripActive;
    next_st.tripRow1 = tripActive;
    next_st.tripCodeShow = tripActive && flashPhase;
    next_st.freeze = tripActive && tripCode != TRIP_UV;
    // display mode
    if (tripActive && !st.tripPrev)
      next_st.mode = DM_STATUS;
    else if (press[KEY_PARAM])
      next_st.mode = DM_PARAM;
    else if (rampIf.enable && (press[KEY_UP] || press[KEY_DOWN]))
      next_st.mode = DM_KEYREF;
    // keypad run, stop and reverse commands
    next_st.stopCmd = keypadCtl && st.ctrl[CTRL_STOPEN] &&
      press[KEY_STOP] && !st.syncB[KEY_RUN];
    next_st.runCmd = keypadCtl && press[KEY_RUN];
    next_st.revCmd = keypadCtl && st.ctrl[CTRL_REVEN] &&
      press[KEY_REV];
    // reset and defaults
    next_st.driveReset = doReset;
    next_st.loadDefaults = doReset && eefTrip;
    // stop key reset waits for a fresh run edge; set wins over clear
    next_st.runPrev = runInputs;
    if (doReset && stopReset)
      next_st.holdOff = 1'b1;
    else if (|(runInputs & ~st.runPrev))
      next_st.holdOff = 1'b0;
    next_st.runPermit = !tripActive && !next_st.holdOff && enableIn &&
      anyRun && (!st.ctrl[CTRL_LATCH] || notStopIn);
    // card save point flash
    if (cardSaved)
      next_st.cardCnt = 26'(CARD_CYC);
    else if (st.cardCnt != '0)
      next_st.cardCnt = st.cardCnt - 26'h0000001;
    next_st.dp[0] = st.cardCnt != '0 && flashPhase;
    next_st.dp[1] = st.ctrl[CTRL_MOTOR2];
  end

  // state register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.ctrl <= CTRL_RESET_VAL;
    end
    else
      st <= next_st;
  end

  // outputs
  assign prdata = st.rdata;
  assign pready = psel && penable;
  assign pslverr = psel && penable && st.rerr;
  assign alarmCode = st.alarm;
  assign alarmShow = st.alarmShow;
  assign tripRow1 = st.tripRow1;
  assign tripCodeShow = st.tripCodeShow;
  assign dispMode = st.mode;
  assign freezeMonitors = st.freeze;
  assign keypadControl = keypadCtl;
  assign revKeyActive = keypadCtl && st.ctrl[CTRL_REVEN];
  assign keyRef = rampIf.speedRef;
  assign decimalPoints = st.dp;
  assign stopCmd = st.stopCmd;
  assign runCmd = st.runCmd;
  assign revCmd = st.revCmd;
  assign driveReset = st.driveReset;
  assign loadDefaults = st.loadDefaults;
  assign runPermit = st.runPermit;

  // checks on the display and reset logic
  edit_quiet_a: assert property (@(posedge clock)
    disable iff (!nrst) editActive |=> !alarmShow)
    else $error("alarm shown in edit");
  alarm_phase_a: assert property (@(posedge clock)
    disable iff (!nrst) alarmShow && alarmCode != ALM_PROG |->
    $past(flashPhase)) else $error("alarm outside flash phase");
  brake_first_a: assert property (@(posedge clock)
    disable iff (!nrst) brakeCond |=> alarmCode == ALM_BRAKE)
    else $error("braking alarm missed");
  ovl_second_a: assert property (@(posedge clock)
    disable iff (!nrst) !brakeCond && ovlCond |=> alarmCode == ALM_OVL)
    else $error("overload alarm missed");
  trip_freeze_a: assert property (@(posedge clock)
    disable iff (!nrst) (tripActive && tripCode != TRIP_UV) [*2] |->
    freezeMonitors) else $error("monitors not frozen");
  hf_keys_a: assert property (@(posedge clock)
    disable iff (!nrst) hfTrip && tripActive == $past(tripActive) |=>
    dispMode == $past(dispMode))
    else $error("key acted in hardware fault");
  comms_reset_a: assert property (@(posedge clock)
    disable iff (!nrst) commsReset && !eefTrip |=> driveReset)
    else $error("user trip reset missed");
  eef_block_a: assert property (@(posedge clock)
    disable iff (!nrst) eefTrip && !eefOk |=> !driveReset && !loadDefaults)
    else $error("reset accepted in eeprom fault");
  hold_off_a: assert property (@(posedge clock)
    disable iff (!nrst) $rose(st.holdOff) |-> !runPermit)
    else $error("restart before fresh run edge");
  trip_row_a: assert property (@(posedge clock)
    disable iff (!nrst) $rose(tripActive) |=>
    tripRow1 && dispMode == DM_STATUS)
    else $error("trip not shown");
endmodule

// ===== atd_keypad_model.sv
// operator keypad model: turns key requests into pin levels
// assumes requests change only at rising clock edges
`timescale 1ns/100ps
module atd_keypad_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [5:0] keyReq,
  output logic [5:0] keyPins
);
  // pins follow requests one edge late, any mix may be held at once
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      keyPins <= 6'h00;
    else
      keyPins <= keyReq;
  end
endmodule

// ===== atd_top_tb_top.sv
// self-checking bench for the alarm, trip display and reset block
// assumes the atd package, ramp carrier and keypad model are compiled
`timescale 1ns/100ps
module atd_top_tb_top;
  import atd_pkg::*;
  localparam int FL = 64;
  localparam int PG = 1000;
  localparam int CD = 300;
  logic clock, nrst, psel, penable, pwrite, pready, pslverr;
  logic editActive, heatsinkAlarm, boardAlarm, tripActive, cardSaved;
  logic brakeSwitching, autotuneActive, limitStopActive, programRunning;
  logic driveRunning, enableIn, notStopIn;
  logic [7:0] paddr, tripCode;
  logic [31:0] pwdata, prdata, rdat;
  logic [5:0] keyPins, keyReq, almIn;
  logic [15:0] brakeTherm, ovlAccum, outCurrent;
  logic [2:0] runInputs;
  logic [1:0] decimalPoints;
  logic signed [15:0] keyRef;
  atd_alarm_t alarmCode;
  atd_mode_t dispMode;
  logic alarmShow, tripRow1, tripCodeShow, freezeMonitors, keypadControl;
  logic revKeyActive, stopCmd, runCmd, revCmd, driveReset, loadDefaults;
  logic runPermit, er;
  int num_errors, n_compared, nRes, nDef, nStop, c, i, r0, d1, d2, e;
  int nRun, nRev; // keypad run and reverse command pulses
  // alarm sources packed for the priority walk
  assign brakeSwitching = almIn[0];
  assign ovlAccum = almIn[1] ? 16'h02EF : 16'h02EE;
  assign heatsinkAlarm = almIn[2];
  assign autotuneActive = almIn[3];
  assign limitStopActive = almIn[4];
  assign programRunning = almIn[5];
  atd_top #(.FLASH_CYC(FL), .PROG_CYC(PG), .CARD_CYC(CD), .STEP_CYC(8),
    .ACCEL_CYC(40)) uut (.*);
  atd_keypad_model kp (.clock(clock), .nrst(nrst), .keyReq(keyReq),
    .keyPins(keyPins));
  // free running clock
  always #20 clock = ~clock;
  // pulse counters
  always @(posedge clock)
  begin
    nRes += (driveReset === 1'b1);
    nDef += (loadDefaults === 1'b1);
    nStop += (stopCmd === 1'b1);
    nRun += (runCmd === 1'b1);
    nRev += (revCmd === 1'b1);
  end
  task close_out();
    if (num_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] x);
    n_compared++;
    if (g !== x)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // wait cycles, end where outputs are settled
  task tick(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  // one apb transfer, waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      num_errors++;
      close_out();
    end
    tick(2);
  endtask
  task key(input int k, input logic v);
    @(posedge clock);
    keyReq[k] <= v;
    tick(6);
  endtask
  task press(input int k);
    key(k, 1'b1);
    key(k, 1'b0);
  endtask
  task cnt(input int s, input int n);
    c = 0;
    repeat (n)
    begin
      @(negedge clock);
      if (s == 0) c += (alarmShow === 1'b1);
      if (s == 1) c += (tripCodeShow === 1'b1);
      if (s == 2) c += (decimalPoints[0] === 1'b1);
    end
  endtask
  task drv(input logic [2:0] run, input logic dr, input logic ns);
    @(posedge clock);
    runInputs <= run;
    driveRunning <= dr;
    notStopIn <= ns;
    tick(3);
  endtask
  initial
  begin
    {clock, nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {editActive, boardAlarm, tripActive, tripCode, cardSaved} = '0;
    {driveRunning, enableIn, notStopIn, runInputs, keyReq, almIn} = '0;
    {brakeTherm, outCurrent, num_errors, n_compared} = '0;
    {nRes, nDef, nStop, nRun, nRev} = '0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    tick(4);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rdat, 32'h20);
    apb(1'b0, 8'h18, 32'h0);
    chk({rdat, er}, 33'h1);
    apb(1'b1, OFS_RATED, 32'h100);
    // alarm thresholds and priority walk
    @(posedge clock);
    brakeTherm <= 16'h02EE;
    almIn <= 6'h01;
    outCurrent <= 16'h0101;
    tick(3);
    chk(alarmCode, ALM_NONE);
    @(posedge clock);
    brakeTherm <= 16'h02EF;
    almIn <= 6'h3F;
    for (i = 0; i < 6; i++)
    begin
      tick(3);
      chk(alarmCode, i + 1);
      @(posedge clock);
      almIn[i] <= 1'b0;
    end
    @(posedge clock);
    almIn <= 6'h02;
    outCurrent <= 16'h0100;
    tick(3);
    chk(alarmCode, ALM_NONE);
    @(posedge clock);
    almIn <= 6'h00;
    boardAlarm <= 1'b1;
    tick(3);
    chk(alarmCode, ALM_HEAT);
    @(posedge clock);
    boardAlarm <= 1'b0;
    almIn <= 6'h01;
    tick(3);
    cnt(0, FL);
    chk(c, FL / 2);
    @(posedge clock);
    editActive <= 1'b1;
    tick(3);
    cnt(0, FL);
    chk(c, 0);
    @(posedge clock);
    editActive <= 1'b0;
    almIn <= 6'h20;
    tick(3);
    cnt(0, PG);
    chk(c, FL / 2);
    @(posedge clock);
    almIn <= 6'h00;
    // keypad control and reference ramp
    apb(1'b1, OFS_CTRL, 32'h34);
    chk({keypadControl, revKeyActive}, 2'h3);
    press(KEY_REV);
    apb(1'b1, OFS_CTRL, 32'h24);
    chk(revKeyActive, 1'b0);
    press(KEY_REV);
    chk(nRev, 1);
    key(KEY_UP, 1'b1);
    chk(dispMode, DM_KEYREF);
    r0 = keyRef;
    tick(16);
    d1 = keyRef - r0;
    tick(200);
    r0 = keyRef;
    tick(16);
    d2 = keyRef - r0;
    chk(d1 > 0, 1);
    chk(d2 > d1, 1);
    key(KEY_UP, 1'b0);
    r0 = keyRef;
    press(KEY_DOWN);
    chk(keyRef < r0, 1);
    // stop key resets, hold-off until fresh run edge
    @(posedge clock);
    enableIn <= 1'b1;
    drv(3'b001, 1'b0, 1'b1);
    press(KEY_STOP);
    chk({nRes, runPermit}, 2);
    drv(3'b000, 1'b0, 1'b1);
    drv(3'b010, 1'b1, 1'b1);
    chk(runPermit, 1'b1);
    press(KEY_STOP);
    chk({nRes, nStop}, 64'h1_0000_0002);
    key(KEY_RUN, 1'b1);
    press(KEY_STOP);
    key(KEY_RUN, 1'b0);
    chk({nRes, nRun}, 64'h2_0000_0001);
    apb(1'b1, OFS_CTRL, 32'h04);
    press(KEY_STOP);
    chk(nRes, 3);
    drv(3'b000, 1'b1, 1'b1);
    drv(3'b100, 1'b1, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h124);
    chk({nRes, runPermit}, 9);
    apb(1'b1, OFS_CTRL, 32'h164);
    chk(nRes, 4);
    drv(3'b100, 1'b1, 1'b0);
    chk(runPermit, 1'b0);
    drv(3'b100, 1'b1, 1'b1);
    chk(runPermit, 1'b1);
    apb(1'b1, OFS_UTRIP, 32'h63);
    chk(nRes, 4);
    apb(1'b1, OFS_UTRIP, 32'h64);
    chk(nRes, 5);
    // trips: hardware fault, ordinary, undervoltage, eeprom
    @(posedge clock);
    tripCode <= TRIP_HF_FIRST;
    tripActive <= 1'b1;
    tick(3);
    chk({tripRow1, dispMode}, 3'h4);
    press(KEY_PARAM);
    press(KEY_STOP);
    chk({nRes, dispMode}, 34'h14);
    for (i = 0; i < 3; i++)
    begin
      @(posedge clock);
      tripActive <= 1'b0;
      @(posedge clock);
      tripCode <= (i == 0) ? 8'h05 : ((i == 1) ? TRIP_UV : TRIP_EEF);
      tripActive <= 1'b1;
      tick(3);
      chk(freezeMonitors, i != 1);
    end
    cnt(1, FL);
    chk(c, FL / 2);
    press(KEY_PARAM);
    chk(dispMode, DM_PARAM);
    for (i = 0; i < 2; i++)
    begin
      e = nRes;
      apb(1'b1, OFS_ACTION, 32'h0);
      apb(1'b1, OFS_UTRIP, 32'h64);
      chk(nRes, e);
      apb(1'b1, OFS_ACTION, i ? ACT_DEFAULTS_B : ACT_DEFAULTS_A);
      apb(1'b1, OFS_UTRIP, 32'h64);
      chk({nRes, nDef}, {e + 1, i + 1});
    end
    // decimal points
    apb(1'b1, OFS_CTRL, 32'hA4);
    chk(decimalPoints[1], 1'b1);
    @(posedge clock);
    cardSaved <= 1'b1;
    @(posedge clock);
    cardSaved <= 1'b0;
    cnt(2, CD);
    chk(c > 0, 1);
    tick(4);
    cnt(2, FL);
    chk(c, 0);
    close_out();
  end
endmodule
